/* core/hbc_cfg.svh */
`ifndef HBC_CFG_SVH
`define HBC_CFG_SVH
// register byte offsets
`define HBC_CTRL 8'h00
`define HBC_ORMASK 8'h04
`define HBC_ANDMASK 8'h08
`define HBC_RNGSEL 8'h0c
`define HBC_RNGLO 8'h10
`define HBC_RNGHI 8'h14
`define HBC_SEQ 8'h18
`define HBC_STT0 8'h1c
`define HBC_STT1 8'h20
`define HBC_STT2 8'h24
`define HBC_STTX 8'h28
`define HBC_EXCMASK 8'h2c
`define HBC_DELAY 8'h30
`define HBC_STATUS 8'h34
`define HBC_IRQSTAT 8'h38
`define HBC_IRQMASK 8'h3c
// control word bit positions
`define HBC_C_OREN 0
`define HBC_C_CMPEN 1
`define HBC_C_MODE 2
`define HBC_C_EXCEN 5
`define HBC_C_TRIGEN 6
`define HBC_C_TRIGLVL 7
`define HBC_C_APPLY 8
`define HBC_C_RESUME 9
// field positions inside other words
`define HBC_SEQ_CNT 24
`define HBC_SEQ_RST 28
`define HBC_STTX_BRK 4
`define HBC_PATH_W 9
`define HBC_PATHS_PER_REG 3
`define HBC_STAT_SEEN 16
// reset values
`define HBC_OREN_RST 1'b1
`define HBC_CMPEN_RST 1'b0
`define HBC_DELAY_RST 16'h0000
`define HBC_SEQCNT_RST 3'h6
// counts
`define HBC_NSTAGE 6
`define HBC_NPATH 9
// bus answers
`define HBC_RESP_OKAY 2'b00
`define HBC_RESP_SLVERR 2'b10
`endif

/* core/hbc_pkg.sv */
package hbc_pkg;
	// compound condition choice
	typedef enum logic [2:0] {
		HBC_MODE_ACC = 3'h0, HBC_MODE_SIM = 3'h1, HBC_MODE_RNG = 3'h2,
		HBC_MODE_SEQ = 3'h3, HBC_MODE_STT = 3'h4
	} hbc_mode_t;
	// state-transition machine states
	typedef enum logic [2:0] {HBC_ST_A = 3'h1, HBC_ST_B = 3'h2, HBC_ST_C = 3'h4} hbc_stt_t;
	// bus slave states
	typedef enum logic [2:0] {HBC_AX_IDLE = 3'h1, HBC_AX_WR = 3'h2, HBC_AX_RD = 3'h4} hbc_ax_t;
	// one transition path
	typedef struct packed {
		logic en;
		logic [1:0] src;
		logic [1:0] dst;
		logic [3:0] ev;
	} hbc_path_t;
	// full break configuration, kept twice (edited and applied)
	typedef struct packed {
		logic orEn;
		logic cmpEn;
		hbc_mode_t mode;
		logic excEn;
		logic trigEn;
		logic trigLvl;
		logic [15:0] orMask;
		logic [15:0] andMask;
		logic [3:0] rngEv;
		logic [23:0] rngLo;
		logic [23:0] rngHi;
		logic [5:0][3:0] seqEv;
		logic [2:0] seqCnt;
		logic [3:0] seqRst;
		hbc_path_t [8:0] path;
		logic [3:0] sttRst;
		logic [1:0] sttBrk;
		logic [7:0] excMask;
		logic [15:0] delay;
	} hbc_cfg_t;
	// axi4-lite master to slave
	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} hbc_axi_req_t;
	// axi4-lite slave to master
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} hbc_axi_rsp_t;
endpackage

/* core/hbc_axil_slave.sv */
`timescale 1ns/1ns
`include "hbc_cfg.svh"
module hbc_axil_slave (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus
	input wire hbc_pkg::hbc_axi_req_t axiReq,
	output hbc_pkg::hbc_axi_rsp_t axiRsp,
	// register file side
	output logic wrEn,
	output logic rdEn,
	input wire logic wrOk,
	input wire logic rdOk,
	input wire logic [31:0] rdData
);
	import hbc_pkg::*;
	// whole slave state
	typedef struct packed {
		hbc_ax_t st;
		logic [1:0] resp;
		logic [31:0] rdata;
	} hbc_axs_t;
	hbc_axs_t s_reg, s_next;
	logic bothW;
	// write needs address and data together; the master offers both at once
	assign bothW = axiReq.awvalid && axiReq.wvalid;
	// next state and strobes
	always_comb begin
		s_next = s_reg;
		wrEn = 1'b0;
		rdEn = 1'b0;
		case (s_reg.st)
			HBC_AX_IDLE: begin
				// write wins a tie so a read never sees half a write
				if (bothW) begin
					wrEn = 1'b1;
					s_next.resp = wrOk ? `HBC_RESP_OKAY : `HBC_RESP_SLVERR;
					s_next.st = HBC_AX_WR;
				end else if (axiReq.arvalid) begin
					rdEn = 1'b1;
					s_next.resp = rdOk ? `HBC_RESP_OKAY : `HBC_RESP_SLVERR;
					s_next.rdata = rdOk ? rdData : 32'h00000000;
					s_next.st = HBC_AX_RD;
				end
			end
			HBC_AX_WR: if (axiReq.bready) s_next.st = HBC_AX_IDLE;
			HBC_AX_RD: if (axiReq.rready) s_next.st = HBC_AX_IDLE;
			default: s_next.st = HBC_AX_IDLE;
		endcase
	end
	// valid comes straight from the state; ready also needs the request
	always_comb begin
		axiRsp.awready = (s_reg.st == HBC_AX_IDLE) && bothW;
		axiRsp.wready = (s_reg.st == HBC_AX_IDLE) && bothW;
		axiRsp.arready = (s_reg.st == HBC_AX_IDLE) && !bothW && axiReq.arvalid;
		axiRsp.bvalid = (s_reg.st == HBC_AX_WR);
		axiRsp.rvalid = (s_reg.st == HBC_AX_RD);
		axiRsp.bresp = s_reg.resp;
		axiRsp.rresp = s_reg.resp;
		axiRsp.rdata = s_reg.rdata;
	end
	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '{st: HBC_AX_IDLE, resp: 2'h0, rdata: 32'h00000000};
		end else begin
			s_reg <= s_next;
		end
	end
endmodule

/* core/hbc_delay.sv */
`timescale 1ns/1ns
module hbc_delay (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// control
	input wire logic busStb,
	input wire logic load,
	input wire logic [15:0] value,
	input wire logic clear,
	// state
	output logic busy,
	output logic halt
);
	import hbc_pkg::*;
	// counter state
	typedef struct packed {
		logic [15:0] cnt;
		logic busy;
		logic halt;
	} hbc_dly_t;
	hbc_dly_t s_reg, s_next;
	// load, count down per bus cycle, halt at zero
	always_comb begin
		s_next = s_reg;
		if (clear) begin
			s_next.busy = 1'b0;
			s_next.halt = 1'b0;
		end else if (load && !s_reg.busy && !s_reg.halt) begin
			// a zero delay halts without counting
			if (value == 16'h0000) s_next.halt = 1'b1;
			else begin
				s_next.cnt = value;
				s_next.busy = 1'b1;
			end
		end else if (s_reg.busy && busStb) begin
			// only real bus cycles count down
			if (s_reg.cnt == 16'h0001) begin
				s_next.busy = 1'b0;
				s_next.halt = 1'b1;
			end
			s_next.cnt = s_reg.cnt - 16'h0001;
		end
	end
	// state register
	always_ff @(posedge clk) begin
		if (sys_rst) s_reg <= '{cnt: 16'h0000, busy: 1'b0, halt: 1'b0};
		else s_reg <= s_next;
	end
	assign busy = s_reg.busy;
	assign halt = s_reg.halt;
endmodule

/* core/hbc_break_unit.sv */
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "hbc_cfg.svh"
module hbc_break_unit (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register bus
	input wire hbc_pkg::hbc_axi_req_t axiReq,
	output hbc_pkg::hbc_axi_rsp_t axiRsp,
	// target bus cycle
	input wire logic busStb,
	input wire logic [23:0] busAddr,
	input wire logic [15:0] evHit,
	input wire logic extTrig,
	input wire logic [7:0] excEv,
	// results
	output logic haltReq,
	output logic irq
);
	import hbc_pkg::*;

	// all block state
	typedef struct packed {
		hbc_cfg_t sh;
		hbc_cfg_t act;
		logic [15:0] seen;
		logic [2:0] stage;
		hbc_stt_t stt;
		logic fire;
		logic [1:0] irqStat;
		logic [1:0] irqMask;
		logic haltD;
	} hbc_state_t;
	hbc_state_t s_reg, s_next;
	// slave strobes and read data
	logic wrEn;
	logic rdEn;
	logic wrOk;
	logic rdOk;
	logic [31:0] rdData;
	// delay counter view
	logic dlyBusy;
	logic dlyHalt;
	logic dlyClear;
	// combined event vector and path results
	logic [15:0] ev;
	logic [15:0] evQ;
	logic orHit;
	logic cmpHit;
	logic excHit;
	logic [31:0] wrWord;
	logic [31:0] clrBits;
	// defaults seen after reset
	function automatic hbc_cfg_t cfgDefault();
		hbc_cfg_t c;
		c = '0;
		c.orEn = `HBC_OREN_RST;
		c.cmpEn = `HBC_CMPEN_RST;
		c.mode = HBC_MODE_ACC;
		c.seqCnt = `HBC_SEQCNT_RST;
		c.delay = `HBC_DELAY_RST;
		return c;
	endfunction

	// word offsets that answer OKAY
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `HBC_IRQMASK);
	endfunction

	// byte enables spread to bit mask
	function automatic logic [31:0] laneMask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{strb[i]}};
		return m;
	endfunction

	// config register readback, also used to merge partial writes
	function automatic logic [31:0] cfgRead(input hbc_cfg_t c, input logic [7:0] a);
		logic [31:0] w;
		int base;
		w = '0;
		base = 0;
		case (a)
			`HBC_CTRL: begin
				w[`HBC_C_OREN] = c.orEn;
				w[`HBC_C_CMPEN] = c.cmpEn;
				w[`HBC_C_MODE +: 3] = c.mode;
				w[`HBC_C_EXCEN] = c.excEn;
				w[`HBC_C_TRIGEN] = c.trigEn;
				w[`HBC_C_TRIGLVL] = c.trigLvl;
			end
			`HBC_ORMASK: w[15:0] = c.orMask;
			`HBC_ANDMASK: w[15:0] = c.andMask;
			`HBC_RNGSEL: w[3:0] = c.rngEv;
			`HBC_RNGLO: w[23:0] = c.rngLo;
			`HBC_RNGHI: w[23:0] = c.rngHi;
			`HBC_SEQ: begin
				w[23:0] = c.seqEv;
				w[`HBC_SEQ_CNT +: 3] = c.seqCnt;
				w[`HBC_SEQ_RST +: 4] = c.seqRst;
			end
			`HBC_STT0, `HBC_STT1, `HBC_STT2: begin
				base = (int'(a) - int'(`HBC_STT0)) / 4 * `HBC_PATHS_PER_REG;
				for (int k = 0; k < `HBC_PATHS_PER_REG; k++)
					w[k*`HBC_PATH_W +: `HBC_PATH_W] = c.path[base + k];
			end
			`HBC_STTX: begin
				w[3:0] = c.sttRst;
				w[`HBC_STTX_BRK +: 2] = c.sttBrk;
			end
			`HBC_EXCMASK: w[7:0] = c.excMask;
			`HBC_DELAY: w[15:0] = c.delay;
			default: w = '0;
		endcase
		return w;
	endfunction

	// config register write; apply and resume bits are not stored
	function automatic hbc_cfg_t cfgWrite(input hbc_cfg_t c, input logic [7:0] a,
			input logic [31:0] w);
		hbc_cfg_t n;
		int base;
		n = c;
		base = 0;
		case (a)
			`HBC_CTRL: begin
				n.orEn = w[`HBC_C_OREN];
				n.cmpEn = w[`HBC_C_CMPEN];
				n.mode = hbc_mode_t'(w[`HBC_C_MODE +: 3]);
				n.excEn = w[`HBC_C_EXCEN];
				n.trigEn = w[`HBC_C_TRIGEN];
				n.trigLvl = w[`HBC_C_TRIGLVL];
			end
			`HBC_ORMASK: n.orMask = w[15:0];
			`HBC_ANDMASK: n.andMask = w[15:0];
			`HBC_RNGSEL: n.rngEv = w[3:0];
			`HBC_RNGLO: n.rngLo = w[23:0];
			`HBC_RNGHI: n.rngHi = w[23:0];
			`HBC_SEQ: begin
				n.seqEv = w[23:0];
				n.seqCnt = w[`HBC_SEQ_CNT +: 3];
				n.seqRst = w[`HBC_SEQ_RST +: 4];
			end
			`HBC_STT0, `HBC_STT1, `HBC_STT2: begin
				base = (int'(a) - int'(`HBC_STT0)) / 4 * `HBC_PATHS_PER_REG;
				for (int k = 0; k < `HBC_PATHS_PER_REG; k++)
					n.path[base + k] = w[k*`HBC_PATH_W +: `HBC_PATH_W];
			end
			`HBC_STTX: begin
				n.sttRst = w[3:0];
				n.sttBrk = w[`HBC_STTX_BRK +: 2];
			end
			`HBC_EXCMASK: n.excMask = w[7:0];
			`HBC_DELAY: n.delay = w[15:0];
			default: n = c;
		endcase
		return n;
	endfunction

	// one-hot state to index and back
	function automatic logic [1:0] sttIdx(input hbc_stt_t st);
		case (st)
			HBC_ST_B: return 2'h1;
			HBC_ST_C: return 2'h2;
			default: return 2'h0;
		endcase
	endfunction
	function automatic hbc_stt_t sttOf(input logic [1:0] i);
		case (i)
			2'h1: return HBC_ST_B;
			2'h2: return HBC_ST_C;
			default: return HBC_ST_A;
		endcase
	endfunction

	// register bus slave
	hbc_axil_slave u_slave (
		.clk(clk),
		.sys_rst(sys_rst),
		.axiReq(axiReq),
		.axiRsp(axiRsp),
		.wrEn(wrEn),
		.rdEn(rdEn),
		.wrOk(wrOk),
		.rdOk(rdOk),
		.rdData(rdData)
	);

	// delay between break and halt
	hbc_delay u_delay (
		.clk(clk),
		.sys_rst(sys_rst),
		.busStb(busStb),
		.load(s_reg.fire),
		.value(s_reg.act.delay),
		.clear(dlyClear),
		.busy(dlyBusy),
		.halt(dlyHalt)
	);

	// address decode for both directions
	assign wrOk = mapped(axiReq.awaddr);
	assign rdOk = mapped(axiReq.araddr);
	// write word merged by byte enables
	assign wrWord = (cfgRead(s_reg.sh, axiReq.awaddr) & ~laneMask(axiReq.wstrb))
		| (axiReq.wdata & laneMask(axiReq.wstrb));
	assign clrBits = axiReq.wdata & laneMask(axiReq.wstrb);
	// apply or resume releases a pending halt
	assign dlyClear = wrEn && (axiReq.awaddr == `HBC_CTRL)
		&& (clrBits[`HBC_C_APPLY] || clrBits[`HBC_C_RESUME]);

	// read mux: edited settings, live status, interrupt words
	always_comb begin
		rdData = '0;
		case (axiReq.araddr)
			`HBC_STATUS: begin
				rdData[0] = dlyHalt;
				rdData[1] = dlyBusy;
				rdData[4:2] = s_reg.stage;
				rdData[6:5] = sttIdx(s_reg.stt);
				rdData[`HBC_STAT_SEEN +: 16] = s_reg.seen;
			end
			`HBC_IRQSTAT: rdData[1:0] = s_reg.irqStat;
			`HBC_IRQMASK: rdData[1:0] = s_reg.irqMask;
			default: rdData = cfgRead(s_reg.sh, axiReq.araddr);
		endcase
	end

	// event vector; only the applied copy steers detection
	always_comb begin
		ev = evHit; // sixteen slots, nothing beyond them
		// slot 15 follows the trigger pin when enabled
		if (s_reg.act.trigEn) ev[15] = (extTrig == s_reg.act.trigLvl);
		// detectors look once per bus cycle
		evQ = busStb ? ev : 16'h0000;
		orHit = s_reg.act.orEn && |(evQ & s_reg.act.orMask);
		// exceptional sources each gated by own enable
		excHit = s_reg.act.excEn && busStb && |(excEv & s_reg.act.excMask);
	end

	// compound path and register updates
	always_comb begin
		logic taken;
		logic [1:0] nxt;
		logic [15:0] acc;
		logic [2:0] last;
		taken = 1'b0;
		nxt = 2'h0;
		acc = '0;
		last = '0;
		cmpHit = 1'b0;
		s_next = s_reg;
		// compound logic runs only when the path is on
		if (s_reg.act.cmpEn) begin
			case (s_reg.act.mode)
				HBC_MODE_ACC: begin
					// remember each event as it occurs
					acc = s_reg.seen | (evQ & s_reg.act.andMask);
					s_next.seen = acc;
					cmpHit = (s_reg.act.andMask != 16'h0000)
						&& ((acc & s_reg.act.andMask) == s_reg.act.andMask);
				end
				HBC_MODE_SIM: begin
					// every selected detector in this same cycle
					cmpHit = (s_reg.act.andMask != 16'h0000)
						&& ((evQ & s_reg.act.andMask) == s_reg.act.andMask);
				end
				HBC_MODE_RNG: begin
					// event only counts inside the address window
					cmpHit = evQ[s_reg.act.rngEv] && (busAddr >= s_reg.act.rngLo)
						&& (busAddr <= s_reg.act.rngHi);
				end
				HBC_MODE_SEQ: begin
					// stage count clamped to 1..6
					if (s_reg.act.seqCnt == 3'h0) last = 3'h0;
					else if (s_reg.act.seqCnt > 3'(`HBC_NSTAGE)) last = 3'(`HBC_NSTAGE - 1);
					else last = s_reg.act.seqCnt - 3'h1;
					if (evQ[s_reg.act.seqRst]) begin
						s_next.stage = 3'h0; // reset point wins
					end else if (evQ[s_reg.act.seqEv[s_reg.stage]]) begin
						if (s_reg.stage >= last) begin
							cmpHit = 1'b1; // last stage seen
							s_next.stage = 3'h0;
						end else begin
							s_next.stage = s_reg.stage + 3'h1;
						end
					end
				end
				HBC_MODE_STT: begin
					// lowest numbered matching path wins
					for (int p = 0; p < `HBC_NPATH; p++) begin
						if (!taken && s_reg.act.path[p].en
								&& (s_reg.act.path[p].src == sttIdx(s_reg.stt))
								&& (s_reg.act.path[p].dst != 2'h3)
								&& evQ[s_reg.act.path[p].ev]) begin
							taken = 1'b1;
							nxt = s_reg.act.path[p].dst;
						end
					end
					if (evQ[s_reg.act.sttRst]) begin
						s_next.stt = HBC_ST_A; // reset point
					end else if (taken) begin
						s_next.stt = sttOf(nxt);
						cmpHit = (nxt == s_reg.act.sttBrk);
					end
				end
				default: cmpHit = 1'b0;
			endcase
		end
		// any enabled path may raise the break, registered first
		s_next.fire = orHit || cmpHit || excHit;
		// a fired accumulation starts over
		if (s_next.fire) s_next.seen = '0;
		// host writes go to the edited copy, interrupt mask writes to irqMask
		if (wrEn) begin
			case (axiReq.awaddr)
				`HBC_IRQMASK: s_next.irqMask = wrWord[1:0];
				default: s_next.sh = cfgWrite(s_reg.sh, axiReq.awaddr, wrWord);
			endcase
			// apply copies edited settings into the live copy
			if ((axiReq.awaddr == `HBC_CTRL) && clrBits[`HBC_C_APPLY]) begin
				s_next.act = cfgWrite(s_reg.sh, axiReq.awaddr, wrWord);
				s_next.seen = '0;
				s_next.stage = 3'h0;
				s_next.stt = HBC_ST_A;
				s_next.fire = 1'b0;
			end
		end
		// sticky events: write one clears, a new event wins over the clear
		s_next.irqStat = (wrEn && (axiReq.awaddr == `HBC_IRQSTAT))
			? (s_reg.irqStat & ~clrBits[1:0]) : s_reg.irqStat;
		s_next.irqStat[0] = s_next.irqStat[0] | s_reg.fire;
		s_next.irqStat[1] = s_next.irqStat[1] | (dlyHalt && !s_reg.haltD);
		s_next.haltD = dlyHalt;
	end
	// state register; both copies start with the or path on, compound off
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s_reg <= '{sh: cfgDefault(), act: cfgDefault(), seen: 16'h0000, stage: 3'h0,
				stt: HBC_ST_A, fire: 1'b0, irqStat: 2'h0, irqMask: 2'h0, haltD: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end
	// outputs
	assign haltReq = dlyHalt;
	assign irq = |(s_reg.irqStat & s_reg.irqMask);
endmodule

/* test/hbc_break_unit_monitor.sv */
`timescale 1ns/1ns
module hbc_break_unit_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register bus
	input wire hbc_pkg::hbc_axi_req_t axiReq,
	input wire hbc_pkg::hbc_axi_rsp_t axiRsp,
	// target bus and results
	input wire logic busStb,
	input wire logic haltReq,
	input wire logic irq
);
	import hbc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// any control write may carry apply or resume
	logic ctrlWr;
	assign ctrlWr = axiReq.awvalid && axiReq.wvalid && axiReq.awaddr == 8'h00;
	// sync reset leaves halt and both bus responses quiet
	property p_rst_quiet;
		disable iff (1'b0) sys_rst |=> !haltReq && !axiRsp.bvalid && !axiRsp.rvalid;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("results not quiet after reset");
	// halt only drops around a control write
	property p_halt_hold;
		haltReq && !ctrlWr && !$past(ctrlWr) && !$past(ctrlWr, 2) |=> haltReq;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt dropped on its own");
	// halt rises only right after a counted bus cycle
	property p_halt_src;
		$rose(haltReq) |-> $past(busStb) || $past(busStb, 2);
	endproperty
	a_halt_src: assert property (p_halt_src) else $error("halt without bus cycle");
	property p_aw_pair;
		axiRsp.awready |-> axiReq.awvalid && axiReq.wvalid && axiRsp.wready;
	endproperty
	a_aw_pair: assert property (p_aw_pair) else $error("address taken without data");
	property p_b_lat;
		axiRsp.awready && axiReq.awvalid |=> axiRsp.bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write response late");
	property p_r_lat;
		axiRsp.arready && axiReq.arvalid |=> axiRsp.rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response late");
	property p_r_hold;
		axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data not held");
	// a pending write pair wins over a read
	property p_ar_idle;
		axiRsp.arready |-> !(axiReq.awvalid && axiReq.wvalid) && !axiRsp.bvalid;
	endproperty
	a_ar_idle: assert property (p_ar_idle) else $error("read taken while busy");
	property p_b_one;
		axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid;
	endproperty
	a_b_one: assert property (p_b_one) else $error("write response repeated");
	c_halt: cover property ($rose(haltReq));
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (axiRsp.rvalid && axiRsp.rresp == 2'b10);
endmodule
bind hbc_break_unit hbc_break_unit_monitor i_mon (.clk(clk), .sys_rst(sys_rst), .axiReq(axiReq),
	.axiRsp(axiRsp), .busStb(busStb), .haltReq(haltReq), .irq(irq));

/* test/hbc_tgt_model.sv */
`timescale 1ns/1ns
module hbc_tgt_model (
	// clock
	input wire logic clk,
	// target bus cycle
	output logic busStb,
	output logic [23:0] busAddr,
	output logic [15:0] evHit,
	output logic extTrig,
	output logic [7:0] excEv
);
	initial begin
		busStb = 0;
		busAddr = 24'h0;
		evHit = 16'h0;
		extTrig = 0;
		excEv = 8'h0;
	end
	// one slot per call; idle slots show inverted address, event and exception junk, never stale data
	task drive(input logic s, input logic t, input logic [7:0] x, input logic [23:0] a,
		input logic [15:0] e);
		busStb <= s;
		extTrig <= t;
		busAddr <= s ? a : ~busAddr;
		evHit <= s ? e : ~evHit;
		excEv <= s ? x : ~excEv;
	endtask
endmodule

/* test/tb_hardware_break_condition_unit.sv */
`timescale 1ns/1ns
`include "hbc_cfg.svh"
module tb_hardware_break_condition_unit;
	import hbc_pkg::*;
	logic clk = 0;
	logic sys_rst = 1;
	hbc_axi_req_t axiReq = '0;
	hbc_axi_rsp_t axiRsp;
	logic busStb, extTrig, haltReq, irq;
	logic [23:0] busAddr;
	logic [15:0] evHit;
	logic [7:0] excEv;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int stage, st, i;
	logic [31:0] rs = 32'h39da49de;
	logic [31:0] r32;
	logic [31:0] img [16];
	logic [31:0] live [16];
	logic [15:0] seen;
	logic [49:0] q [$];
	int dlyList [3] = '{1, 5, 65535};
	logic [23:0] adrList [3] = '{24'hff, 24'h200, 24'h1ff};
	int seqList [8] = '{1, 2, 4, 2, 3, 1, 2, 3};
	int sttList [5] = '{6, 5, 7, 5, 6};
	always #25 clk = ~clk;
	// hang guard, longest delay run included
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			errors++;
			give_verdict();
		end
	end
	hbc_break_unit i_hbc_break_unit (.clk(clk), .sys_rst(sys_rst), .axiReq(axiReq),
		.axiRsp(axiRsp), .busStb(busStb), .busAddr(busAddr), .evHit(evHit), .extTrig(extTrig),
		.excEv(excEv), .haltReq(haltReq), .irq(irq));
	hbc_tgt_model i_hbc_tgt_model (.clk(clk), .busStb(busStb), .busAddr(busAddr),
		.evHit(evHit), .extTrig(extTrig), .excEv(excEv));
	task give_verdict();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	function logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// write; the model mirrors edited and applied copies
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 0;
		w = 0;
		@(posedge clk);
		axiReq <= '{1'b1, a, 1'b1, d, 4'hf, 1'b1, 1'b0, 8'h00, 1'b0};
		while (!(aw && w)) begin
			@(posedge clk);
			if (axiRsp.awready) begin
				aw = 1;
				axiReq.awvalid <= 0;
			end
			if (axiRsp.wready) begin
				w = 1;
				axiReq.wvalid <= 0;
			end
		end
		while (!axiRsp.bvalid) @(posedge clk);
		chk_word({30'h0, axiRsp.bresp}, 32'h0);
		axiReq.bready <= 0;
		if (a == `HBC_CTRL) begin
			img[0] = d & 32'hff;
			if (d[`HBC_C_APPLY]) begin
				live = img;
				seen = 0;
				stage = 0;
				st = 0;
			end
		end else if (a < 8'h40 && a != `HBC_STATUS && a != `HBC_IRQSTAT) img[a[5:2]] = d;
	endtask
	// read with late ready so the slave must hold its answer
	task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		axiReq.arvalid <= 1;
		axiReq.araddr <= a;
		do @(posedge clk); while (!axiRsp.arready);
		axiReq.arvalid <= 0;
		@(posedge clk);
		axiReq.rready <= 1;
		do @(posedge clk); while (!axiRsp.rvalid);
		axiReq.rready <= 0;
		chk_word(axiRsp.rdata, e);
		chk_word({30'h0, axiRsp.rresp}, {30'h0, er});
	endtask
	// reference break decision for one valid bus cycle
	function logic mfire(input logic [15:0] e, input logic [23:0] a, input logic [7:0] x,
		input logic t);
		logic [31:0] c, p;
		logic [15:0] m;
		int n;
		logic h;
		c = live[0];
		m = live[2][15:0];
		if (c[6]) e[15] = (t == c[7]);
		h = c[0] && |(e & live[1][15:0]);
		h |= c[5] && |(x & live[11][7:0]);
		if (c[1]) case (c[4:2])
			3'h0: begin
				seen |= e & m;
				h |= m != 0 && (seen & m) == m;
			end
			3'h1: h |= m != 0 && (e & m) == m;
			3'h2: h |= e[live[3][3:0]] && a >= live[4][23:0] && a <= live[5][23:0];
			3'h3: begin
				n = live[6][26:24] == 0 ? 1 : live[6][26:24] > 6 ? 6 : live[6][26:24];
				if (e[live[6][31:28]]) stage = 0;
				else if (e[live[6][stage * 4 +: 4]]) begin
					stage++;
					if (stage == n) h = 1;
				end
			end
			3'h4: if (e[live[10][3:0]]) st = 0;
			else for (int k = 0; k < 9; k++) begin
				p = live[7 + k / 3] >> (k % 3 * 9);
				if (p[8] && p[7:6] == st && p[5:4] != 3 && e[p[3:0]]) begin
					st = p[5:4];
					h |= st == live[10][5:4];
					break;
				end
			end
			default: ;
		endcase
		return h;
	endfunction
	task pu(input logic s, input logic t, input logic [7:0] x, input logic [23:0] a,
		input logic [15:0] e);
		q.push_back({s, t, x, a, e});
	endtask
	// play the queue, then idle valid cycles; halt must follow the first fire
	task run(input int d);
		int f, k;
		logic [49:0] v;
		f = -1;
		for (k = 0; k < q.size() + d + 4; k++) begin
			@(posedge clk);
			v = k < q.size() ? q[k] : {1'b1, 49'h0};
			i_hbc_tgt_model.drive(v[49], v[48], v[47:40], v[39:16], v[15:0]);
			if (f < 0 && v[49] && mfire(v[15:0], v[39:16], v[47:40], v[48])) f = k;
			#1 chk_bit(haltReq, f >= 0 && k >= f + 2 + d);
		end
		q.delete();
	endtask
	task scen(input logic [31:0] c, input int d);
		wr(`HBC_CTRL, c);
		run(d);
	endtask
	initial begin
		img = '{default: 32'h0};
		img[0] = 32'h1;
		img[6] = 32'h06000000;
		live = img;
		seen = 0;
		stage = 0;
		st = 0;
		repeat (10) @(posedge clk);
		sys_rst <= 0;
		rchk(`HBC_CTRL, 32'h1, `HBC_RESP_OKAY);
		rchk(`HBC_DELAY, 32'h0, `HBC_RESP_OKAY);
		rchk(`HBC_SEQ, 32'h06000000, `HBC_RESP_OKAY);
		rchk(8'h40, 32'h0, `HBC_RESP_SLVERR);
		// edited but not applied: no break yet
		wr(`HBC_IRQMASK, 32'h1);
		wr(`HBC_ORMASK, 32'h8);
		pu(1, 0, 0, 0, 16'h8);
		run(0);
		pu(1, 0, 0, 0, 16'h8);
		scen(32'h101, 0);
		chk_bit(irq, 1);
		wr(`HBC_IRQSTAT, 32'h3);
		repeat (2) @(posedge clk);
		chk_bit(irq, 0);
		rchk(`HBC_IRQSTAT, 32'h0, `HBC_RESP_OKAY);
		// random detectors with idle gaps; idle events must be ignored
		r32 = rnd();
		wr(`HBC_ORMASK, {16'h0, r32[15:0]});
		for (i = 0; i < 12; i++) begin
			r32 = rnd();
			pu(r32[31], 0, 0, 0, r32[15:0]);
		end
		scen(32'h101, 0);
		wr(`HBC_IRQMASK, 32'h0);
		// fixed or mask so the delay runs never depend on the random one
		wr(`HBC_ORMASK, 32'h8);
		foreach (dlyList[j]) begin
			wr(`HBC_DELAY, dlyList[j]);
			pu(1, 0, 0, 0, 16'h0);
			pu(1, 0, 0, 0, 16'h8);
			scen(32'h101, dlyList[j]);
		end
		chk_bit(irq, 0);
		wr(`HBC_DELAY, 32'h0);
		// compound modes with the or path off
		wr(`HBC_ANDMASK, 32'h6);
		pu(1, 0, 0, 0, 16'h2);
		pu(1, 0, 0, 0, 16'h0);
		pu(1, 0, 0, 0, 16'h4);
		scen(32'h102, 0);
		pu(1, 0, 0, 0, 16'h2);
		pu(1, 0, 0, 0, 16'h4);
		pu(1, 0, 0, 0, 16'h6);
		scen(32'h106, 0);
		wr(`HBC_RNGSEL, 32'h1);
		wr(`HBC_RNGLO, 32'h100);
		wr(`HBC_RNGHI, 32'h1ff);
		foreach (adrList[j]) pu(1, 0, 0, adrList[j], 16'h2);
		scen(32'h10a, 0);
		wr(`HBC_SEQ, 32'h43000321);
		foreach (seqList[j]) pu(1, 0, 0, 0, 16'h1 << seqList[j]);
		scen(32'h10e, 0);
		// back-to-back transitions are harmless
		wr(`HBC_STT0, 32'h2cd15);
		wr(`HBC_STTX, 32'h27);
		foreach (sttList[j]) pu(1, 0, 0, 0, 16'h1 << sttList[j]);
		scen(32'h112, 0);
		// halted, machine parked in the third state, nothing accumulated
		rchk(`HBC_STATUS, 32'h41, `HBC_RESP_OKAY);
		// each exception source alone, its neighbour masked off
		for (i = 0; i < 8; i++) begin
			wr(`HBC_EXCMASK, 32'h1 << i);
			pu(1, 0, 8'h1 << ((i + 1) % 8), 0, 16'h0);
			pu(1, 0, 8'h1 << i, 0, 16'h0);
			scen(32'h120, 0);
		end
		wr(`HBC_ORMASK, 32'h8000);
		pu(1, 0, 0, 0, 16'h0);
		pu(1, 1, 0, 0, 16'h0);
		scen(32'h1c1, 0);
		wr(`HBC_CTRL, 32'h200);
		repeat (2) @(posedge clk);
		chk_bit(haltReq, 0);
		give_verdict();
	end
endmodule
